/* File: decoder_index_home_pin_mux.sv */
// decoder index/home pin multiplexer: routes two pins to decoder, timer, spi or gpio
// assumes synchronous config strobes from logic on i_core_clk; pins and strap are async
//
// What this block does
// - full variant leaves the index pin on the decoder index input after reset.
// - full variant leaves the home pin on the decoder home input after reset.
// - index alternate select routes the index pin to the spi slave output line.
// - home alternate select routes the home pin to the spi slave select line.
// - clearing pull-up bit 2 disconnects the index pin pull-up.
// - clearing pull-up bit 3 disconnects the home pin pull-up.
// - unselected spi slave keeps its slave output line in high impedance.
// - slave output line is sampled in master mode and driven in slave mode.
// - in master mode the slave select input arbitrates between masters.
// - external master drives slave select; slave responds only while it is low.
// - in gpio mode each pin direction is set individually by software.
// - index pin can be timer channel two, home pin timer channel three.
`timescale 1ns/100ps
module decoder_index_home_pin_mux
  import pin_mux_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_full_variant,
  input wire logic i_index_pin,
  output logic o_index_pin,
  output logic o_index_pin_oe_n,
  input wire logic i_home_pin,
  output logic o_home_pin,
  output logic o_home_pin_oe_n,
  input wire logic i_cfg_load,
  input wire pin_cfg_t i_index_cfg,
  input wire pin_cfg_t i_home_cfg,
  input wire logic i_pur_load,
  input wire logic [PUR_WIDTH-1:0] i_port_c_pullup_enable_register,
  output logic o_index_pullup_enable,
  output logic o_home_pullup_enable,
  input wire timer_drive_t i_timer_b_channel_two,
  input wire timer_drive_t i_timer_b_channel_three,
  input wire logic i_spi_master_mode,
  input wire logic i_spi_slave_output_line,
  output logic o_decoder_index_input,
  output logic o_decoder_home_input,
  output logic o_timer_b_channel_two,
  output logic o_timer_b_channel_three,
  output logic o_port_c_bit_two,
  output logic o_port_c_bit_three,
  output logic o_spi_slave_output_line,
  output logic o_spi_slave_select_line,
  output logic o_spi_mode_fault,
  output logic o_boot_done
);

  // state
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;
  logic [1:0] boot_cnt_reg;
  logic boot_done_reg;
  pin_fn_t fn_reg [PIN_COUNT];
  logic [1:0] pur_reg;
  logic [1:0] out_reg;
  logic [1:0] oe_n_reg;
  logic [1:0] dec_reg;
  logic [1:0] tmr_reg;
  logic [1:0] gpio_reg;
  logic miso_in_reg;
  logic ss_in_reg;
  logic fault_reg;

  // decode of configuration and drive requests
  pin_cfg_t cfg [PIN_COUNT];
  timer_drive_t tdrv [PIN_COUNT];
  pin_fn_t fn_next [PIN_COUNT];
  logic [1:0] spi_drive;
  logic [1:0] spi_data;
  logic [1:0] out_next;
  logic [1:0] oe_n_next;
  logic [1:0] pur_next;
  logic cfg_take;
  logic slave_selected;
  logic boot_last;

  assign cfg[PIN_INDEX] = i_index_cfg;
  assign cfg[PIN_HOME] = i_home_cfg;
  assign tdrv[PIN_INDEX] = i_timer_b_channel_two;
  assign tdrv[PIN_HOME] = i_timer_b_channel_three;
  // config writes wait for the strap capture so they cannot be overwritten by it
  assign cfg_take = i_cfg_load && boot_done_reg;
  assign boot_last = !boot_done_reg && (boot_cnt_reg == BOOT_CYCLES);
  // selected only while the external master holds the home pin low
  assign slave_selected = (fn_reg[PIN_HOME] == FN_SPI) && !pin_sync_reg[PIN_HOME];
  // only the index pin carries spi data; slave select is an input only
  assign spi_drive[PIN_INDEX] = !i_spi_master_mode && slave_selected;
  assign spi_drive[PIN_HOME] = 1'b0;
  assign spi_data[PIN_INDEX] = i_spi_slave_output_line;
  assign spi_data[PIN_HOME] = 1'b0;
  assign pur_next[0] = i_port_c_pullup_enable_register[PUR_INDEX_BIT];
  assign pur_next[1] = i_port_c_pullup_enable_register[PUR_HOME_BIT];

  // per-pin function choice and pad drive
  generate
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
      // gpio wins over the alternate select, which wins over the timer
      assign fn_next[p] = cfg[p].gpio_en ? FN_GPIO :
                          cfg[p].alt_sel ? FN_SPI :
                          cfg[p].timer_sel ? FN_TIMER : FN_DECODER;
      assign out_next[p] = (fn_reg[p] == FN_TIMER) ? tdrv[p].out :
                           (fn_reg[p] == FN_SPI) ? spi_data[p] :
                           (fn_reg[p] == FN_GPIO) ? cfg[p].gpio_data : 1'b0;
      assign oe_n_next[p] = (fn_reg[p] == FN_TIMER) ? !tdrv[p].oe :
                            (fn_reg[p] == FN_SPI) ? !spi_drive[p] :
                            (fn_reg[p] == FN_GPIO) ? !cfg[p].gpio_dir : 1'b1;

      // function register: strap decides the first value, software the rest
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          fn_reg[p] <= FN_NONE;
        end else if (i_clk_en) begin
          if (boot_last) begin
            fn_reg[p] <= strap_sync_reg ? FN_DECODER : FN_NONE;
          end else if (cfg_take) begin
            fn_reg[p] <= fn_next[p];
          end
        end
      end

      // pad and core-side registers; unused decoder and timer inputs idle high like the pull-up
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          out_reg[p] <= 1'b0;
          oe_n_reg[p] <= OE_N_RESET[p];
          dec_reg[p] <= PIN_IDLE[p];
          tmr_reg[p] <= PIN_IDLE[p];
          gpio_reg[p] <= PIN_IDLE[p];
        end else if (i_clk_en) begin
          out_reg[p] <= out_next[p];
          oe_n_reg[p] <= oe_n_next[p];
          dec_reg[p] <= (fn_reg[p] == FN_DECODER) ? pin_sync_reg[p] : 1'b1;
          tmr_reg[p] <= (fn_reg[p] == FN_TIMER) ? pin_sync_reg[p] : 1'b1;
          gpio_reg[p] <= pin_sync_reg[p];
        end
      end
    end
  endgenerate

  // two-flop synchronisers for pins and the variant strap
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_reg <= PIN_IDLE;
      pin_sync_reg <= PIN_IDLE;
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else if (i_clk_en) begin
      pin_meta_reg <= {i_home_pin, i_index_pin};
      pin_sync_reg <= pin_meta_reg;
      strap_meta_reg <= i_full_variant;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // boot counter lets the strap settle through the synchroniser before capture
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      boot_cnt_reg <= 2'h0;
      boot_done_reg <= 1'b0;
    end else if (i_clk_en && !boot_done_reg) begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
      boot_done_reg <= boot_last;
    end
  end

  // pull-up enable bits; held enabled until boot so pins stay pulled during start-up
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pur_reg <= PUR_RESET;
    end else if (i_clk_en && i_pur_load && boot_done_reg) begin
      pur_reg <= pur_next;
    end
  end

  // spi core side: sampled data line, slave select and master arbitration
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      miso_in_reg <= 1'b1;
      ss_in_reg <= 1'b1;
      fault_reg <= 1'b0;
    end else if (i_clk_en) begin
      miso_in_reg <= (fn_reg[PIN_INDEX] == FN_SPI) ? pin_sync_reg[PIN_INDEX] : 1'b1;
      ss_in_reg <= (fn_reg[PIN_HOME] == FN_SPI) ? pin_sync_reg[PIN_HOME] : 1'b1;
      // another master pulling select low while we are master is a mode fault
      fault_reg <= i_spi_master_mode && (fn_reg[PIN_HOME] == FN_SPI)
                   && !pin_sync_reg[PIN_HOME];
    end
  end

  // outputs straight from flops
  assign o_index_pin = out_reg[PIN_INDEX];
  assign o_index_pin_oe_n = oe_n_reg[PIN_INDEX];
  assign o_home_pin = out_reg[PIN_HOME];
  assign o_home_pin_oe_n = oe_n_reg[PIN_HOME];
  assign o_index_pullup_enable = pur_reg[0];
  assign o_home_pullup_enable = pur_reg[1];
  assign o_decoder_index_input = dec_reg[PIN_INDEX];
  assign o_decoder_home_input = dec_reg[PIN_HOME];
  assign o_timer_b_channel_two = tmr_reg[PIN_INDEX];
  assign o_timer_b_channel_three = tmr_reg[PIN_HOME];
  assign o_port_c_bit_two = gpio_reg[PIN_INDEX];
  assign o_port_c_bit_three = gpio_reg[PIN_HOME];
  assign o_spi_slave_output_line = miso_in_reg;
  assign o_spi_slave_select_line = ss_in_reg;
  assign o_spi_mode_fault = fault_reg;
  assign o_boot_done = boot_done_reg;

  // checks
  a_full_index_default: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(boot_done_reg) && strap_sync_reg |-> fn_reg[PIN_INDEX] == FN_DECODER)
    else $error("index pin not on decoder after full-variant boot");
  a_full_home_default: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(boot_done_reg) && strap_sync_reg |-> fn_reg[PIN_HOME] == FN_DECODER)
    else $error("home pin not on decoder after full-variant boot");
  a_reduced_no_fn: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(boot_done_reg) && !strap_sync_reg |-> fn_reg[PIN_INDEX] == FN_NONE
    && oe_n_reg == OE_N_RESET)
    else $error("reduced variant pin got a function at boot");
  a_index_spi_route: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en && cfg_take && !boot_last && i_index_cfg.alt_sel && !i_index_cfg.gpio_en
    |=> fn_reg[PIN_INDEX] == FN_SPI)
    else $error("index alternate select did not route to spi");
  a_home_spi_route: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en && cfg_take && !boot_last && i_home_cfg.alt_sel && !i_home_cfg.gpio_en
    |=> fn_reg[PIN_HOME] == FN_SPI)
    else $error("home alternate select did not route to spi");
  a_index_pullup_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en && i_pur_load && boot_done_reg && !i_port_c_pullup_enable_register[PUR_INDEX_BIT]
    |=> !o_index_pullup_enable)
    else $error("index pull-up stayed on after clear");
  a_home_pullup_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en && i_pur_load && boot_done_reg && !i_port_c_pullup_enable_register[PUR_HOME_BIT]
    |=> !o_home_pullup_enable)
    else $error("home pull-up stayed on after clear");
  a_miso_hiz: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en && fn_reg[PIN_INDEX] == FN_SPI && !slave_selected |=> o_index_pin_oe_n)
    else $error("slave output driven while not selected");
  a_master_sample: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en && fn_reg[PIN_INDEX] == FN_SPI && i_spi_master_mode
    |=> o_index_pin_oe_n && o_spi_slave_output_line == $past(pin_sync_reg[PIN_INDEX]))
    else $error("master mode did not sample the data line");
  a_mode_fault: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en && i_spi_master_mode && fn_reg[PIN_HOME] == FN_SPI && !pin_sync_reg[PIN_HOME]
    |=> o_spi_mode_fault)
    else $error("select low in master mode gave no fault");
  a_gpio_dir: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en && fn_reg[PIN_HOME] == FN_GPIO |=> o_home_pin_oe_n == !$past(i_home_cfg.gpio_dir))
    else $error("gpio direction not followed");
  a_boot_inputs: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !boot_done_reg |-> oe_n_reg == OE_N_RESET && pur_reg == PUR_RESET)
    else $error("pin driven or pull-up off before boot");

endmodule

/* File: decoder_index_home_pin_mux_tb_top.sv */
// self-checking bench for the index/home pin multiplexer
// assumes pad peers on both pins; notes are compared by a watcher process
`timescale 1ns/100ps
module decoder_index_home_pin_mux_tb_top;
  import pin_mux_pkg::*;
  typedef struct {int due; int idx; logic val;} note_t;
  note_t note_q[$];
  int cyc = 0;
  int failures = 0;
  int cmp_count = 0;
  // readable names of the observed outputs, by bit of obs
  string obs_name [16] = '{"index_out", "index_oe_n", "home_out", "home_oe_n", "index_pullup",
    "home_pullup", "decoder_index", "decoder_home", "timer_two", "timer_three", "port_c_two",
    "port_c_three", "spi_data_in", "spi_select_in", "mode_fault", "boot_done"};
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, strap = 1'b1;
  logic cfg_ld = 1'b0, pur_ld = 1'b0, mst = 1'b0, sdo = 1'b0;
  logic [1:0] pen = 2'h0, pval = 2'h0;
  logic [3:0] r;
  logic [15:0] pur = 16'hffff;
  pin_cfg_t ic = '0, hc = '0;
  timer_drive_t t2 = '0, t3 = '0;
  wire logic [15:0] obs;
  wire logic idx_pad, home_pad;

  always #50 clk = ~clk;

  decoder_index_home_pin_mux dut_u (.i_core_clk(clk), .i_rst(rst), .i_clk_en(clk_en),
    .i_full_variant(strap), .i_index_pin(idx_pad), .o_index_pin(obs[0]),
    .o_index_pin_oe_n(obs[1]), .i_home_pin(home_pad), .o_home_pin(obs[2]),
    .o_home_pin_oe_n(obs[3]), .i_cfg_load(cfg_ld), .i_index_cfg(ic), .i_home_cfg(hc),
    .i_pur_load(pur_ld), .i_port_c_pullup_enable_register(pur),
    .o_index_pullup_enable(obs[4]), .o_home_pullup_enable(obs[5]),
    .i_timer_b_channel_two(t2), .i_timer_b_channel_three(t3), .i_spi_master_mode(mst),
    .i_spi_slave_output_line(sdo), .o_decoder_index_input(obs[6]),
    .o_decoder_home_input(obs[7]), .o_timer_b_channel_two(obs[8]),
    .o_timer_b_channel_three(obs[9]), .o_port_c_bit_two(obs[10]),
    .o_port_c_bit_three(obs[11]), .o_spi_slave_output_line(obs[12]),
    .o_spi_slave_select_line(obs[13]), .o_spi_mode_fault(obs[14]), .o_boot_done(obs[15]));
  pad_peer idx_peer (.i_core_clk(clk), .i_dev_out(obs[0]), .i_dev_oe_n(obs[1]),
    .i_pullup(obs[4]), .i_peer_en(pen[0]), .i_peer_val(pval[0]), .o_level(idx_pad));
  pad_peer home_peer (.i_core_clk(clk), .i_dev_out(obs[2]), .i_dev_oe_n(obs[3]),
    .i_pullup(obs[5]), .i_peer_en(pen[1]), .i_peer_val(pval[1]), .o_level(home_pad));

  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input int idx, input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", obs_name[idx], exp, seen);
    end
  endtask
  // note a value due dly rising edges after the current one
  task automatic expect_out(input int idx, input logic val, input int dly);
    note_q.push_back('{cyc + dly + 1, idx, val});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic load_cfg(input pin_cfg_t a, input pin_cfg_t b);
    @(posedge clk);
    ic <= a;
    hc <= b;
    cfg_ld <= 1'b1;
    @(posedge clk);
    cfg_ld <= 1'b0;
  endtask
  // full reset, reset-state checks, then wait out the strap settle count
  task automatic do_reset(input logic variant);
    @(posedge clk);
    rst <= 1'b1;
    strap <= variant;
    tick(10);
    for (int i = 1; i < 8; i += 2) expect_out(i, 1'b1, 0);
    expect_out(4, 1'b1, 0);
    expect_out(6, 1'b1, 0);
    expect_out(15, 1'b0, 0);
    rst <= 1'b0;
    expect_out(15, 1'b1, 4);
    tick(5);
  endtask

  // watcher: compares every note on its due cycle, also cuts a hang short
  always @(negedge clk) begin
    cyc = cyc + 1;
    for (int i = note_q.size() - 1; i >= 0; i--) begin
      if (note_q[i].due == cyc) begin
        check(note_q[i].idx, obs[note_q[i].idx], note_q[i].val);
        note_q.delete(i);
      end
    end
    if (cyc > 3000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    r = 4'($urandom(77145));
    do_reset(1'b1);
    pen <= 2'h3;
    pval <= 2'h0;
    expect_out(6, 1'b0, 3);
    expect_out(7, 1'b0, 3);
    expect_out(8, 1'b1, 3);
    tick(4);
    // timer channels: index driven by the timer, home sampled from the peer
    r = 4'($urandom());
    t2 <= '{out: r[0], oe: 1'b1};
    t3 <= '{out: r[1], oe: 1'b0};
    pen <= 2'h2;
    pval <= r[3:2];
    load_cfg(5'h04, 5'h04);
    expect_out(1, 1'b0, 2);
    expect_out(0, r[0], 2);
    expect_out(2, r[1], 2);
    expect_out(3, 1'b1, 2);
    expect_out(9, r[3], 2);
    expect_out(6, 1'b1, 2);
    tick(4);
    // gpio wins over every other select; direction per pin, used live
    r = 4'($urandom());
    // the home peer must show this scenario's random level, not the last one
    pval <= r[3:2];
    load_cfg({3'h7, 1'b1, r[0]}, {3'h7, 1'b0, r[1]});
    expect_out(10, r[0], 4);
    expect_out(1, 1'b0, 2);
    expect_out(0, r[0], 2);
    expect_out(3, 1'b1, 2);
    expect_out(11, r[3], 2);
    tick(3);
    ic.gpio_dir <= 1'b0;
    expect_out(1, 1'b1, 1);
    tick(4);
    // spi slave: output line stays released until slave select goes low
    r = 4'($urandom());
    pen <= 2'h2;
    pval <= 2'h2;
    sdo <= r[0];
    load_cfg(5'h08, 5'h08);
    expect_out(1, 1'b1, 2);
    expect_out(13, 1'b1, 2);
    tick(3);
    pval <= 2'h0;
    expect_out(1, 1'b0, 3);
    expect_out(0, r[0], 3);
    expect_out(13, 1'b0, 3);
    tick(5);
    // spi master: index pin becomes an input, low select flags a fault
    mst <= 1'b1;
    sdo <= ~r[0];
    expect_out(0, ~r[0], 1);
    expect_out(1, 1'b1, 1);
    tick(2);
    pen <= 2'h3;
    pval <= {1'b0, r[1]};
    expect_out(12, r[1], 3);
    expect_out(14, 1'b1, 3);
    tick(4);
    pval[1] <= 1'b1;
    expect_out(14, 1'b0, 3);
    tick(4);
    // clock enable low freezes the synchronisers, so a low select raises no fault yet
    clk_en <= 1'b0;
    pval[1] <= 1'b0;
    expect_out(14, 1'b0, 4);
    tick(4);
    clk_en <= 1'b1;
    expect_out(14, 1'b1, 3);
    tick(4);
    // pull-up bits 2 and 3 in both polarities, other bits random
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pur <= {16'($urandom()) & 16'hfff3} | {12'h0, k[0], ~k[0], 2'h0};
      pur_ld <= 1'b1;
      @(posedge clk);
      pur_ld <= 1'b0;
      expect_out(4, ~k[0], 1);
      expect_out(5, k[0], 1);
      tick(3);
    end
    // reduced variant: no function after boot, decoder inputs stay idle
    mst <= 1'b0;
    pval <= 2'h0;
    do_reset(1'b0);
    expect_out(6, 1'b1, 3);
    expect_out(7, 1'b1, 3);
    tick(6);
    report_and_stop();
  end
endmodule

/* File: pad_peer.sv */
// outside party on one pad: encoder, timer peer or spi master
// assumes the device pad out, enable and pull-up as seen at the pin
`timescale 1ns/100ps
module pad_peer (
  input wire logic i_core_clk,
  input wire logic i_dev_out,
  input wire logic i_dev_oe_n,
  input wire logic i_pullup,
  input wire logic i_peer_en,
  input wire logic i_peer_val,
  output logic o_level
);
  logic float_reg = 1'b0;
  // a released pad with no pull-up must not keep its old level, so it toggles
  always @(posedge i_core_clk) begin
    float_reg <= ~float_reg;
  end
  // device drive first, then the peer (it drives slave select), then pull-up
  assign o_level = !i_dev_oe_n ? i_dev_out : i_peer_en ? i_peer_val :
                   i_pullup ? 1'b1 : float_reg;
endmodule

/* File: pin_mux_pkg.sv */
// package for the decoder index/home pin multiplexer
// assumes one core clock; all other cores sit outside and talk over plain ports
package pin_mux_pkg;

  // one-hot function of a pin
  typedef enum logic [4:0] {
    FN_NONE    = 5'h01,
    FN_DECODER = 5'h02,
    FN_TIMER   = 5'h04,
    FN_SPI     = 5'h08,
    FN_GPIO    = 5'h10
  } pin_fn_t;

  // pin index inside the two-entry arrays
  localparam int PIN_INDEX = 0;
  localparam int PIN_HOME = 1;
  localparam int PIN_COUNT = 2;

  // port c pull-up enable register layout
  localparam int PUR_WIDTH = 16;
  localparam int PUR_INDEX_BIT = 2;
  localparam int PUR_HOME_BIT = 3;
  localparam logic [1:0] PUR_RESET = 2'h3;

  // cycles after reset release before the variant strap is trusted
  localparam logic [1:0] BOOT_CYCLES = 2'h3;

  // reset values of pin and core-side outputs
  localparam logic [1:0] OE_N_RESET = 2'h3;
  localparam logic [1:0] PIN_IDLE = 2'h3;

  // per-pin software configuration (gpio enable, alternate select, etc.)
  typedef struct packed {
    logic gpio_en;
    logic alt_sel;
    logic timer_sel;
    logic gpio_dir;
    logic gpio_data;
  } pin_cfg_t;

  // drive request from a timer channel
  typedef struct packed {
    logic out;
    logic oe;
  } timer_drive_t;

endpackage
